// ==== verilog/bpm_pkg.sv ====
/*
 * Package for the battery power mode controller: mode encoding, event flag
 * register offset and bit positions, reset values and timing counts.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bpm_pkg;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BPM_RESET     = 3'b000,
        BPM_MISSION   = 3'b001,
        BPM_BROWNOUT  = 3'b010,
        BPM_DISPLAY   = 3'b011,
        BPM_SLEEP     = 3'b100,
        BPM_PLL_WAIT  = 3'b101
    } bpm_mode_e;

    // ------------------------------------------------------------
    // Event flag register
    // ------------------------------------------------------------
    localparam logic [7:0] BPM_EVENT_FLAGS_ADDR = 8'hE8;
    localparam int BPM_PLL_FALL_BIT = 7;
    localparam int BPM_PLL_RISE_BIT = 6;
    localparam int BPM_WAKE_BIT = 5;
    localparam int BPM_PUSHBUTTON_BIT = 4;
    localparam logic [7:0] BPM_EVENT_FLAGS_RESET = 8'h00;
    localparam logic [7:0] BPM_EVENT_FLAGS_MASK = 8'hF0;

    // ------------------------------------------------------------
    // Timing: PLL settle after system power returns, in oscillator clocks
    // ------------------------------------------------------------
    localparam int BPM_PLL_SETTLE_OSC_CLOCKS = 4100;

endpackage : bpm_pkg

// ==== verilog/bpm_power_mode_ctrl.sv ====
/*
 * Battery power mode controller: tracks mission, brownout, display-only and
 * sleep modes, holds the four mode event flags at special register 0xE8 and
 * drives processor run, configuration reset and converter/engine gating.
 * Assumes: pins power fail, headroom and pushbutton are asynchronous and are
 * synchronised here; firmware register access arrives as single-cycle strobes
 * on i_mclk; oscillator clock ticks arrive as a one-cycle pulse i_osc_tick
 * from same-domain logic.
 */
`timescale 1ns/100ps

// What this block does
// R1: Mission mode only while system supply present and PLL reported stable.
// R2: Enter brownout when supply fails, or on battery wake with margin.
// R3: From brownout, display-only or sleep request bits enter that mode, halting CPU.
// R4: Only one request takes effect; the first one wins and halts the CPU.
// R5: Set PLL-fall flag, bit 7, on mission to brownout move.
// R6: Set PLL-rise flag, bit 6, when PLL stabilises toward mission.
// R7: Leave display-only or sleep for brownout only on wake timer or pushbutton.
// R8: Set pushbutton flag, bit 4, when pushbutton pin goes high.
// R9: Set wake-timer flag, bit 5, whenever the wake timer times out.
// R10: Without system supply, lost regulator headroom forces sleep mode.
// R11: Stay in sleep after headroom loss even if headroom returns.
// R12: Firmware should move brownout to sleep when supply missing.
// R13: Firmware should enter sleep once a battery is attached in production.
// R14: Supply restored: any battery mode goes to mission once PLL settles.
// R15: While PLL not stable, force converter and engine enables to zero.
// R16: After supply returns, hold CPU in reset for 4100 oscillator clocks.
// R17: Brownout to mission keeps configuration; from display or sleep it resets.
// R18: Event flags stay set until firmware clears them; they can interrupt.
module bpm_power_mode_ctrl #(
    parameter int PLL_SETTLE_CLOCKS = bpm_pkg::BPM_PLL_SETTLE_OSC_CLOCKS
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_power_fail_sense_input,
    input wire logic i_battery_headroom_ok,
    input wire logic i_pushbutton_pin,
    input wire logic i_wake_timeout,
    input wire logic i_osc_tick,
    input wire logic i_display_only_request,
    input wire logic i_sleep_request,
    input wire logic i_adc_enable,
    input wire logic i_engine_enable,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [2:0] o_mode,
    output logic o_pll_stable,
    output logic o_cpu_run,
    output logic o_config_reset,
    output logic o_adc_enable,
    output logic o_engine_enable,
    output logic o_event_irq
);
    import bpm_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pf_sync;
    logic [1:0] bat_sync;
    logic [1:0] pb_sync;
    logic pb_prev;
    logic [1:0] sync_fill; // Ones walk in behind the synchronisers after reset
    logic supply_ok;
    logic headroom_ok;
    logic pb_rise;

    // Two stages each; only stage two feeds logic
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pf_sync <= 2'h0;
            bat_sync <= 2'h0;
            pb_sync <= 2'h0;
            pb_prev <= 1'b0;
            sync_fill <= 2'h0;
        end else begin
            pf_sync <= {pf_sync[0], i_power_fail_sense_input};
            bat_sync <= {bat_sync[0], i_battery_headroom_ok};
            pb_sync <= {pb_sync[0], i_pushbutton_pin};
            pb_prev <= pb_sync[1];
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    assign supply_ok = pf_sync[1];
    assign headroom_ok = bat_sync[1];
    assign pb_rise = pb_sync[1] & ~pb_prev;

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    bpm_mode_e mode;
    bpm_mode_e next_mode;
    logic [12:0] settle_cnt;
    logic [12:0] next_settle_cnt;
    logic settle_done;
    logic wake_event;
    logic cfg_lost;
    logic next_cfg_lost;

    assign settle_done = (settle_cnt >= 13'(PLL_SETTLE_CLOCKS));
    assign wake_event = i_wake_timeout | pb_rise;

    // Next mode; supply return outranks every battery-mode exit
    always_comb begin
        next_mode = mode;
        next_settle_cnt = settle_cnt;
        next_cfg_lost = cfg_lost;
        unique case (mode)
            BPM_RESET: begin
                // Fresh start: supply decides the path, config is at reset anyway
                next_cfg_lost = 1'b1;
                next_settle_cnt = 13'h0000;
                if (!sync_fill[1]) begin
                    // Pins not yet through both stages; deciding now would see a false outage
                    next_mode = BPM_RESET;
                end else if (supply_ok) begin
                    next_mode = BPM_PLL_WAIT;
                end else if (headroom_ok) begin
                    next_mode = BPM_BROWNOUT; // R2
                end else begin
                    next_mode = BPM_SLEEP; // R10
                end
            end
            BPM_PLL_WAIT: begin
                // CPU held in reset while the PLL settles
                if (!supply_ok) begin
                    next_mode = headroom_ok ? BPM_BROWNOUT : BPM_SLEEP; // R2 R10
                end else if (settle_done) begin
                    next_mode = BPM_MISSION; // R14 R16
                end else if (i_osc_tick) begin
                    next_settle_cnt = settle_cnt + 13'h0001; // R16
                end
            end
            BPM_MISSION: begin
                next_cfg_lost = 1'b0;
                if (!supply_ok) begin
                    next_mode = headroom_ok ? BPM_BROWNOUT : BPM_SLEEP; // R1 R2 R10
                end
            end
            BPM_BROWNOUT: begin
                next_settle_cnt = 13'h0000;
                if (supply_ok) begin
                    next_mode = BPM_PLL_WAIT; // R14
                end else if (!headroom_ok) begin
                    next_mode = BPM_SLEEP; // R10
                end else if (i_display_only_request) begin
                    next_mode = BPM_DISPLAY; // R3 R4
                end else if (i_sleep_request) begin
                    next_mode = BPM_SLEEP; // R3 R4
                end
            end
            BPM_DISPLAY, BPM_SLEEP: begin
                // Waking here drops configuration; headroom return alone does nothing
                next_cfg_lost = 1'b1; // R17
                next_settle_cnt = 13'h0000;
                if (supply_ok) begin
                    next_mode = BPM_PLL_WAIT; // R14
                end else if (mode == BPM_DISPLAY && !headroom_ok) begin
                    next_mode = BPM_SLEEP; // R10
                end else if (wake_event && headroom_ok) begin
                    next_mode = BPM_BROWNOUT; // R7 R11
                end
            end
            default: begin
                next_mode = BPM_RESET;
            end
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mode <= BPM_RESET;
            settle_cnt <= 13'h0000;
            cfg_lost <= 1'b1;
        end else begin
            mode <= next_mode;
            settle_cnt <= next_settle_cnt;
            cfg_lost <= next_cfg_lost;
        end
    end

    // ------------------------------------------------------------
    // Event flags, set wins over firmware clear
    // ------------------------------------------------------------
    logic [7:0] flags;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;
    logic flag_wr;

    assign flag_wr = i_reg_wr & (i_reg_addr == BPM_EVENT_FLAGS_ADDR);
    // Firmware clears a flag by writing zero to its bit
    assign clr_mask = flag_wr ? (~i_reg_wdata & BPM_EVENT_FLAGS_MASK) : 8'h00;

    always_comb begin
        set_mask = 8'h00;
        set_mask[BPM_PLL_FALL_BIT] = (mode == BPM_MISSION) && (next_mode != BPM_MISSION); // R5
        set_mask[BPM_PLL_RISE_BIT] = (mode == BPM_PLL_WAIT) && (next_mode == BPM_MISSION); // R6
        set_mask[BPM_WAKE_BIT] = i_wake_timeout; // R9
        set_mask[BPM_PUSHBUTTON_BIT] = pb_rise; // R8
    end

    // Sticky until cleared; a same-cycle event survives the clear
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags <= BPM_EVENT_FLAGS_RESET;
        end else begin
            flags <= (flags & ~clr_mask) | set_mask; // R18
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic pll_ok;

    assign pll_ok = (mode == BPM_MISSION); // R1
    assign o_reg_rdata = (i_reg_addr == BPM_EVENT_FLAGS_ADDR) ? flags : 8'h00;
    assign o_mode = mode;
    assign o_pll_stable = pll_ok;
    // Processor runs only in mission and brownout
    assign o_cpu_run = (mode == BPM_MISSION) || (mode == BPM_BROWNOUT); // R3 R16
    assign o_config_reset = cfg_lost && (mode != BPM_MISSION) && (mode != BPM_BROWNOUT); // R17
    assign o_adc_enable = i_adc_enable & pll_ok; // R15
    assign o_engine_enable = i_engine_enable & pll_ok; // R15
    assign o_event_irq = |flags; // R18

endmodule : bpm_power_mode_ctrl

// ==== tb/bpm_power_mode_ctrl_properties.sv ====
/* Port checker for the power mode controller.
   Assumes a bind onto bpm_power_mode_ctrl, one clock domain. */
`timescale 1ns/100ps
module bpm_power_mode_ctrl_properties (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_adc_enable,
    input wire logic i_display_only_request,
    input wire logic i_sleep_request,
    input wire logic i_reg_wr,
    input wire logic [2:0] o_mode,
    input wire logic o_pll_stable,
    input wire logic o_cpu_run,
    input wire logic o_adc_enable,
    input wire logic o_event_irq
);
    import bpm_pkg::*;
    // ------------------------------------------------------------
    // Mode steps and properties
    // ------------------------------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_low; o_mode == BPM_DISPLAY || o_mode == BPM_SLEEP; endsequence
    sequence s_to_mission; o_mode != BPM_MISSION ##1 o_mode == BPM_MISSION; endsequence
    property p_gate; o_adc_enable == (i_adc_enable && o_mode == BPM_MISSION); endproperty
    property p_mission; o_mode == BPM_MISSION |-> o_pll_stable && o_cpu_run; endproperty
    property p_enter; s_to_mission |-> $past(o_mode) == BPM_PLL_WAIT && o_event_irq; endproperty
    property p_fall; o_mode == BPM_MISSION ##1 o_mode == BPM_BROWNOUT |-> o_event_irq; endproperty
    property p_req; o_mode == BPM_BROWNOUT && (i_sleep_request || i_display_only_request) |=> !o_cpu_run; endproperty
    property p_wake; s_low ##1 o_mode == BPM_BROWNOUT |-> o_event_irq; endproperty
    property p_hold; o_event_irq && !i_reg_wr |=> o_event_irq; endproperty
    property p_wait; o_mode == BPM_PLL_WAIT |-> !o_cpu_run && !o_pll_stable; endproperty
    a_gate: assert property (p_gate) else $error("enable gate wrong");
    a_mission: assert property (p_mission) else $error("mission outputs wrong");
    a_enter: assert property (p_enter) else $error("bad mission entry");
    a_fall: assert property (p_fall) else $error("no fall flag");
    a_req: assert property (p_req) else $error("request ignored");
    a_wake: assert property (p_wake) else $error("wake without event");
    a_hold: assert property (p_hold) else $error("flag lost");
    a_wait: assert property (p_wait) else $error("cpu runs in settle");
endmodule : bpm_power_mode_ctrl_properties

bind bpm_power_mode_ctrl bpm_power_mode_ctrl_properties bpm_power_mode_ctrl_properties_i (.i_mclk, .i_rst,
    .i_adc_enable, .i_display_only_request, .i_sleep_request, .i_reg_wr, .o_mode, .o_pll_stable, .o_cpu_run,
    .o_adc_enable, .o_event_irq);

// ==== tb/bpm_partner.sv ====
/* Far side: wake timer and oscillator tick.
   Assumes bench commands change on falling edges. */
`timescale 1ns/100ps
module bpm_partner (
    input wire logic i_mclk,
    input wire logic i_fire,
    output logic o_wake,
    output logic o_tick
);
    logic [1:0] div = 2'h0;
    logic [1:0] fire_q = 2'h0;
    // Tick every fourth cycle; timer gives one pulse per fire command
    always @(negedge i_mclk) begin
        div <= div + 2'h1;
        fire_q <= {fire_q[0], i_fire};
    end
    assign o_tick = (div == 2'h3);
    assign o_wake = fire_q[0] & ~fire_q[1];
endmodule : bpm_partner

// ==== tb/tb_bpm_power_mode_ctrl.sv ====
/* Self-checking bench for the power mode controller.
   Assumes package and design compiled first. */
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_bpm_power_mode_ctrl;
    import bpm_pkg::*;
    localparam int SETTLE = 4;
    logic i_mclk = 1'b0, i_rst = 1'b1, sup = 1'b1, hr = 1'b1, btn = 1'b0, fire = 1'b0;
    logic disp = 1'b0, slp = 1'b0, adc = 1'b0, eng = 1'b0, wr = 1'b0, src, wake, tick, cfg, adc_o, eng_o;
    logic pll, run, irq;
    logic [7:0] addr = 8'hE8, wdata = 8'h00, rdata;
    logic [2:0] mode;
    int n_mismatch = 0, check_count = 0, cycles = 0, seed = 32'hef3e, i, k;
    always #2 i_mclk = ~i_mclk;
    bpm_partner bpm_partner_i (.i_mclk, .i_fire(fire), .o_wake(wake), .o_tick(tick));
    bpm_power_mode_ctrl #(.PLL_SETTLE_CLOCKS(SETTLE)) bpm_power_mode_ctrl_i (.i_mclk, .i_rst,
        .i_power_fail_sense_input(sup), .i_battery_headroom_ok(hr), .i_pushbutton_pin(btn), .i_wake_timeout(wake),
        .i_osc_tick(tick), .i_display_only_request(disp), .i_sleep_request(slp), .i_adc_enable(adc),
        .i_engine_enable(eng), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_mode(mode), .o_pll_stable(pll), .o_cpu_run(run), .o_config_reset(cfg), .o_adc_enable(adc_o),
        .o_engine_enable(eng_o), .o_event_irq(irq));
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // Expected {pll stable, cpu run} for a mode
    function automatic logic [1:0] exp_run(input logic [2:0] m);
        return {m == BPM_MISSION, m == BPM_MISSION || m == BPM_BROWNOUT};
    endfunction : exp_run
    // Bounded wait for a mode; k returns cycles spent
    task automatic await(input logic [2:0] m, output int k);
        for (k = 0; k < 100 && mode !== m; k++) @(negedge i_mclk);
        `CHK(mode, m)
        `CHK({pll, run}, exp_run(m))
    endtask : await
    // Read flags, show a stray write elsewhere is ignored, then clear by writing zeros
    task automatic flags(input logic [7:0] exp);
        `CHK(rdata, exp)
        `CHK(irq, |exp)
        addr = 8'hE9;
        wr = 1'b1;
        @(negedge i_mclk);
        `CHK(irq, |exp)
        `CHK(rdata, 8'h00)
        addr = 8'hE8;
        @(negedge i_mclk);
        wr = 1'b0;
        `CHK(rdata, 8'h00)
        `CHK(irq, 1'b0)
    endtask : flags
    // Hang guard, then random enables with gating checked each cycle
    always @(posedge i_mclk) if (++cycles == 20000) begin n_mismatch++; results(); end
    always @(negedge i_mclk) begin
        if (!i_rst) `CHK({adc_o, eng_o}, {adc, eng} & {2{mode === BPM_MISSION}})
        adc <= 1'($random(seed));
        eng <= 1'($random(seed));
    end
    initial begin
        repeat (10) @(negedge i_mclk);
        i_rst = 1'b0;
        await(BPM_MISSION, k);
        flags(8'h40);
        sup = 1'b0;
        await(BPM_BROWNOUT, k);
        flags(8'h80);
        sup = 1'b1;
        await(BPM_PLL_WAIT, k);
        `CHK(cfg, 1'b0)
        await(BPM_MISSION, k);
        `CHK(k >= 4 * SETTLE - 4 && k <= 4 * SETTLE + 1, 1'b1)
        flags(8'h40);
        sup = 1'b0;
        await(BPM_BROWNOUT, k);
        flags(8'h80);
        for (i = 0; i < 6; i++) begin
            disp = (i % 3) != 1;
            slp = (i % 3) != 0;
            await((i % 3) == 1 ? BPM_SLEEP : BPM_DISPLAY, k);
            disp = 1'b0;
            slp = 1'b0;
            repeat (6) @(negedge i_mclk);
            `CHK(mode === BPM_BROWNOUT, 1'b0)
            src = 1'($random(seed));
            fire = src;
            btn = !src;
            repeat (4) @(negedge i_mclk);
            fire = 1'b0;
            btn = 1'b0;
            await(BPM_BROWNOUT, k);
            flags(src ? 8'h20 : 8'h10);
        end
        hr = 1'b0;
        await(BPM_SLEEP, k);
        hr = 1'b1;
        repeat (20) @(negedge i_mclk);
        `CHK(mode, BPM_SLEEP)
        sup = 1'b1;
        await(BPM_PLL_WAIT, k);
        `CHK(cfg, 1'b1)
        await(BPM_MISSION, k);
        flags(8'h40);
        // Restart on battery alone: must come up in brownout, flags cleared
        sup = 1'b0;
        i_rst = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_rst = 1'b0;
        await(BPM_BROWNOUT, k);
        flags(8'h00);
        results();
    end
endmodule : tb_bpm_power_mode_ctrl
